// >>> logic/gpio_port_pkg.sv
`default_nettype none
package gpio_port_pkg;
  // Port shape
  localparam int PIN_COUNT = 6;
  localparam int CH_COUNT = 2;
  localparam int CH_PINS = 3;
  localparam int REG_W = 8;
  localparam int ADDR_W = 18;
  // Register indices; byte address is four times the index
  localparam logic [15:0] DIRECTION_INDEX = 16'hFFB8;
  localparam logic [15:0] DATA_INDEX = 16'hFFBA;
  localparam logic [17:0] DIRECTION_ADDR = {DIRECTION_INDEX, 2'h0};
  localparam logic [17:0] DATA_ADDR = {DATA_INDEX, 2'h0};
  // Reset and read-back values
  localparam logic [7:0] DIRECTION_RESET = 8'hC0;
  localparam logic [7:0] DATA_RESET = 8'hC0;
  localparam logic [7:0] DIRECTION_READ = 8'hFF;
  localparam logic [1:0] RESERVED_READ = 2'h3;
  // Pin roles inside one channel group
  localparam int TX_POS = 0;
  localparam int RX_POS = 1;
  localparam int CLK_POS = 2;
  // AXI responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;
endpackage
`default_nettype wire

// >>> logic/serial_pin_mux.sv
`timescale 1ns/1ps
`default_nettype none
// Function select for the three pins of one serial channel
module serial_pin_mux
  import gpio_port_pkg::*;
(
  input wire logic [CH_PINS-1:0] dir_i,
  input wire logic [CH_PINS-1:0] data_i,
  input wire logic [CH_PINS-1:0] pin_level_i,
  input wire logic release_i,
  input wire logic external_clock_in_enable_i,
  input wire logic internal_clock_out_enable_i,
  input wire logic clocked_mode_i,
  input wire logic receiver_enable_i,
  input wire logic transmitter_enable_i,
  input wire logic transmit_line_i,
  input wire logic serial_clock_out_i,
  output logic [CH_PINS-1:0] pin_o,
  output logic [CH_PINS-1:0] pin_oe_o,
  output logic [CH_PINS-1:0] owned_o,
  output logic receive_line_o,
  output logic serial_clock_in_o
);
  wire clk_in_sel;
  wire clk_out_sel;
  wire rx_sel;
  wire tx_sel;

  // Standby release drops every serial claim at once
  assign clk_in_sel = !release_i && external_clock_in_enable_i; // see (R11)
  assign clk_out_sel = !release_i && !external_clock_in_enable_i &&
                       (clocked_mode_i || internal_clock_out_enable_i); // see (R11)
  assign rx_sel = !release_i && receiver_enable_i; // see (R12)
  assign tx_sel = !release_i && transmitter_enable_i; // see (R13)

  // Owned pins follow the channel, others follow direction and data
  assign owned_o = {clk_in_sel || clk_out_sel, rx_sel, tx_sel};
  assign pin_oe_o[TX_POS] = tx_sel ? 1'b1 : dir_i[TX_POS]; // see (R13) (R2)
  assign pin_o[TX_POS] = tx_sel ? transmit_line_i : data_i[TX_POS];
  assign pin_oe_o[RX_POS] = rx_sel ? 1'b0 : dir_i[RX_POS]; // see (R12) (R2)
  assign pin_o[RX_POS] = data_i[RX_POS];
  assign pin_oe_o[CLK_POS] = clk_in_sel ? 1'b0 :
                             (clk_out_sel ? 1'b1 : dir_i[CLK_POS]); // see (R11) (R2)
  assign pin_o[CLK_POS] = clk_out_sel ? serial_clock_out_i : data_i[CLK_POS];

  // Serial inputs always see the pin; the channel ignores them when idle
  assign receive_line_o = pin_level_i[RX_POS];
  assign serial_clock_in_o = pin_level_i[CLK_POS];
endmodule
`default_nettype wire

// >>> logic/serial_shared_gpio_port.sv
`timescale 1ns/1ps
`default_nettype none
// Operation
// (R1) Six two-way pins; selection never depends on an operating mode.
// (R2) Pin not owned by serial: direction one drives, zero is input.
// (R3) Direction register is write-only; any read returns all ones.
// (R4) Reset and hardware standby load direction with C0; software standby keeps it.
// (R5) Software standby initialises serial channels; pins fall back to general purpose.
// (R6) Data bits 7 and 6 ignore writes and read as one.
// (R7) Output-direction pin reads the latched data bit, not the pin.
// (R8) Input-direction pin reads the sampled pin, also under serial use.
// (R9) Reset and hardware standby load data with C0; software standby keeps it.
// (R10) Channel 0 uses pins 0,1,2 and channel 1 pins 3,4,5.
// (R11) Clock pin: input if external enable, output if clocked or internal.
// (R12) Receive pin is serial input while receiver enabled, else general purpose.
// (R13) Transmit pin drives serial data while transmitter enabled, else general purpose.
// (R14) Data writes always update the latch, whatever the pin function.
module serial_shared_gpio_port
  import gpio_port_pkg::*;
#(
  parameter int ADDR_BITS = ADDR_W
)
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic hw_standby_i,
  input wire logic sw_standby_i,
  input wire logic [ADDR_BITS-1:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_BITS-1:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [gpio_port_pkg::PIN_COUNT-1:0] pin_i,
  output logic [gpio_port_pkg::PIN_COUNT-1:0] pin_o,
  output logic [gpio_port_pkg::PIN_COUNT-1:0] pin_oe_o,
  input wire logic [gpio_port_pkg::CH_COUNT-1:0] external_clock_in_enable_i,
  input wire logic [gpio_port_pkg::CH_COUNT-1:0] internal_clock_out_enable_i,
  input wire logic [gpio_port_pkg::CH_COUNT-1:0] clocked_mode_i,
  input wire logic [gpio_port_pkg::CH_COUNT-1:0] receiver_enable_i,
  input wire logic [gpio_port_pkg::CH_COUNT-1:0] transmitter_enable_i,
  input wire logic [gpio_port_pkg::CH_COUNT-1:0] transmit_line_i,
  input wire logic [gpio_port_pkg::CH_COUNT-1:0] serial_clock_out_i,
  output logic [gpio_port_pkg::CH_COUNT-1:0] receive_line_o,
  output logic [gpio_port_pkg::CH_COUNT-1:0] serial_clock_in_o,
  output logic serial_init_o
);
  import gpio_port_pkg::*;

  // The decode compares full byte addresses, so the bus must carry them
  if (ADDR_BITS != ADDR_W) begin : g_bad_addr_bits
    $error("ADDR_BITS must equal the register address width");
  end

  //////////////////////////////////////////////////////////////////////////////
  // Storage and pin sampling

  logic [PIN_COUNT-1:0] direction;
  logic [PIN_COUNT-1:0] out_data;
  logic [PIN_COUNT-1:0] pin_meta;
  logic [PIN_COUNT-1:0] pin_sync;
  logic [PIN_COUNT-1:0] owned;

  // Two stages before anything looks at the pins
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      pin_meta <= '0;
      pin_sync <= '0;
    end else begin
      pin_meta <= pin_i;
      pin_sync <= pin_meta;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite write path

  logic aw_held;
  logic w_held;
  logic [ADDR_BITS-1:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic bvalid;
  logic [1:0] bresp;

  wire aw_take;
  wire w_take;
  wire do_write;
  wire wr_dir;
  wire wr_data;
  wire wr_low;

  // Address and data are taken in either order, one write at a time
  assign s_axi_awready = !aw_held && !bvalid;
  assign s_axi_wready = !w_held && !bvalid;
  assign aw_take = s_axi_awvalid && s_axi_awready;
  assign w_take = s_axi_wvalid && s_axi_wready;
  assign do_write = aw_held && w_held && !bvalid;
  assign wr_dir = aw_addr == DIRECTION_ADDR[ADDR_BITS-1:0];
  assign wr_data = aw_addr == DATA_ADDR[ADDR_BITS-1:0];
  assign wr_low = w_strb[0]; // Registers live in byte lane 0 only
  assign s_axi_bvalid = bvalid;
  assign s_axi_bresp = bresp;

  // Hold halves until both are present
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      aw_held <= 1'b0;
      aw_addr <= '0;
    end else if (aw_take) begin
      aw_held <= 1'b1;
      aw_addr <= s_axi_awaddr;
    end else if (do_write) begin
      aw_held <= 1'b0;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      w_held <= 1'b0;
      w_data <= '0;
      w_strb <= '0;
    end else if (w_take) begin
      w_held <= 1'b1;
      w_data <= s_axi_wdata;
      w_strb <= s_axi_wstrb;
    end else if (do_write) begin
      w_held <= 1'b0;
    end
  end

  // Response stands until the master takes it
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      bvalid <= 1'b0;
      bresp <= RESP_OKAY;
    end else if (do_write) begin
      bvalid <= 1'b1;
      bresp <= (wr_dir || wr_data) ? RESP_OKAY : RESP_DECERR;
    end else if (s_axi_bready) begin
      bvalid <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Port registers

  // Hardware standby clears like reset; software standby is not seen here
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      direction <= DIRECTION_RESET[PIN_COUNT-1:0]; // see (R4)
    end else if (hw_standby_i) begin
      direction <= DIRECTION_RESET[PIN_COUNT-1:0]; // see (R4)
    end else if (do_write && wr_dir && wr_low) begin
      direction <= w_data[PIN_COUNT-1:0];
    end
  end

  // Reserved top bits are not stored, so writes to them vanish
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      out_data <= DATA_RESET[PIN_COUNT-1:0]; // see (R9)
    end else if (hw_standby_i) begin
      out_data <= DATA_RESET[PIN_COUNT-1:0]; // see (R9)
    end else if (do_write && wr_data && wr_low) begin
      out_data <= w_data[PIN_COUNT-1:0]; // see (R6) (R14)
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite read path

  logic rvalid;
  logic [31:0] rdata;
  logic [1:0] rresp;

  wire ar_take;
  wire rd_dir;
  wire rd_data;
  wire [PIN_COUNT-1:0] port_view;
  wire [31:0] next_rdata;

  // Output-direction pins read the latch, others the sampled level
  assign port_view = (out_data & direction) | (pin_sync & ~direction); // see (R7) (R8)
  assign s_axi_arready = !rvalid;
  assign ar_take = s_axi_arvalid && s_axi_arready;
  assign rd_dir = s_axi_araddr == DIRECTION_ADDR[ADDR_BITS-1:0];
  assign rd_data = s_axi_araddr == DATA_ADDR[ADDR_BITS-1:0];
  assign next_rdata = rd_dir ? {24'h000000, DIRECTION_READ} : // see (R3)
                      rd_data ? {24'h000000, RESERVED_READ, port_view} : // see (R6)
                      32'h00000000;
  assign s_axi_rvalid = rvalid;
  assign s_axi_rdata = rdata;
  assign s_axi_rresp = rresp;

  // Read data is captured once and held until rready
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      rvalid <= 1'b0;
      rdata <= '0;
      rresp <= RESP_OKAY;
    end else if (ar_take) begin
      rvalid <= 1'b1;
      rdata <= next_rdata;
      rresp <= (rd_dir || rd_data) ? RESP_OKAY : RESP_DECERR;
    end else if (s_axi_rready) begin
      rvalid <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Pin function select

  // Channels are told to reset for as long as software standby lasts
  assign serial_init_o = sw_standby_i; // see (R5)

  // Same select in every mode: no mode input exists here
  genvar ch;
  generate
    for (ch = 0; ch < CH_COUNT; ch++) begin : g_ch
      // Channel ch sits on pins 3*ch .. 3*ch+2
      serial_pin_mux u_mux (
        .dir_i(direction[ch*CH_PINS +: CH_PINS]), // see (R10) (R1)
        .data_i(out_data[ch*CH_PINS +: CH_PINS]),
        .pin_level_i(pin_sync[ch*CH_PINS +: CH_PINS]),
        .release_i(sw_standby_i), // see (R5)
        .external_clock_in_enable_i(external_clock_in_enable_i[ch]),
        .internal_clock_out_enable_i(internal_clock_out_enable_i[ch]),
        .clocked_mode_i(clocked_mode_i[ch]),
        .receiver_enable_i(receiver_enable_i[ch]),
        .transmitter_enable_i(transmitter_enable_i[ch]),
        .transmit_line_i(transmit_line_i[ch]),
        .serial_clock_out_i(serial_clock_out_i[ch]),
        .pin_o(pin_o[ch*CH_PINS +: CH_PINS]),
        .pin_oe_o(pin_oe_o[ch*CH_PINS +: CH_PINS]),
        .owned_o(owned[ch*CH_PINS +: CH_PINS]),
        .receive_line_o(receive_line_o[ch]),
        .serial_clock_in_o(serial_clock_in_o[ch])
      );
    end
  endgenerate

  //////////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  sequence data_write_s;
    do_write && wr_data && wr_low && !hw_standby_i;
  endsequence

  sequence data_read_s;
    ar_take && rd_data;
  endsequence

  dir_standby_a: assert property ( // see (R4)
    hw_standby_i |=> direction == DIRECTION_RESET[PIN_COUNT-1:0] [*1] ##1
      (direction == DIRECTION_RESET[PIN_COUNT-1:0] || $past(do_write)))
    else $error("direction not cleared by hardware standby");

  data_standby_a: assert property ( // see (R9)
    hw_standby_i |=> out_data == DATA_RESET[PIN_COUNT-1:0])
    else $error("data not cleared by hardware standby");

  dir_read_ones_a: assert property ( // see (R3)
    ar_take && rd_dir |=> rvalid && rdata[7:0] == DIRECTION_READ)
    else $error("direction read did not return all ones");

  reserved_read_a: assert property ( // see (R6)
    data_read_s |=> rvalid && rdata[7:6] == RESERVED_READ)
    else $error("reserved data bits did not read as one");

  port_read_a: assert property ( // see (R7)
    data_read_s |=> rdata[PIN_COUNT-1:0] ==
      ($past(out_data & direction) | $past(pin_sync & ~direction)))
    else $error("port read mixed latch and pin wrongly");

  data_latch_a: assert property ( // see (R14)
    data_write_s |=> out_data == $past(w_data[PIN_COUNT-1:0]) && bvalid)
    else $error("data write did not reach the latch");

  write_answer_a: assert property (
    aw_take && w_take |=> do_write ##1 bvalid)
    else $error("write response not given two cycles after both halves");

  gpio_drive_a: assert property ( // see (R2)
    ((pin_oe_o ^ direction) & ~owned) == '0)
    else $error("general purpose pin ignores its direction bit");

  standby_release_a: assert property ( // see (R5)
    sw_standby_i |-> owned == '0 && serial_init_o)
    else $error("serial channel kept a pin in software standby");

  tx_drive_a: assert property ( // see (R13)
    transmitter_enable_i[0] && !sw_standby_i |->
      pin_oe_o[TX_POS] && pin_o[TX_POS] == transmit_line_i[0])
    else $error("transmit pin not driven by channel 0");

  rx_input_a: assert property ( // see (R12)
    receiver_enable_i[1] && !sw_standby_i |-> !pin_oe_o[CH_PINS + RX_POS])
    else $error("receive pin of channel 1 is driving");

  clk_select_a: assert property ( // see (R11)
    !sw_standby_i && !external_clock_in_enable_i[0] && clocked_mode_i[0] |->
      pin_oe_o[CLK_POS] && pin_o[CLK_POS] == serial_clock_out_i[0])
    else $error("clock pin of channel 0 not driven as output");

  clk_input_a: assert property ( // see (R11)
    !sw_standby_i && external_clock_in_enable_i[1] |-> !pin_oe_o[CH_PINS + CLK_POS])
    else $error("clock pin of channel 1 drives while clock is external");

  // The second stage only ever copies the first one
  sync_chain_a: assert property (
    pin_sync == $past(pin_meta))
    else $error("pin synchroniser skipped a stage");

  sequence stray_write_s;
    do_write && !wr_dir && !wr_data;
  endsequence

  stray_write_a: assert property (
    stray_write_s |=> bvalid && bresp == RESP_DECERR)
    else $error("unmapped write not answered with a decode error");

  stray_read_a: assert property (
    ar_take && !rd_dir && !rd_data |=>
      rvalid && rresp == RESP_DECERR && rdata == 32'h00000000)
    else $error("unmapped read not answered with a decode error");

  // Bus side band signals carry nothing this block uses
  wire unused_prot;
  assign unused_prot = ^{s_axi_awprot, s_axi_arprot, w_strb[3:1], w_data[31:PIN_COUNT]};
endmodule
`default_nettype wire

// >>> verification/far_side_model.sv
`timescale 1ns/1ps
`default_nettype none
// Outside pins and the two serial channels as the port sees them
module far_side_model
  import gpio_port_pkg::*;
(
  input wire logic clk_i,
  input wire logic [PIN_COUNT-1:0] port_out_i,
  input wire logic [PIN_COUNT-1:0] port_oe_i,
  input wire logic [PIN_COUNT-1:0] ext_drive_i,
  input wire logic [PIN_COUNT-1:0] ext_level_i,
  input wire logic serial_init_i,
  output logic [PIN_COUNT-1:0] pin_level_o,
  output logic [CH_COUNT-1:0] transmit_line_o,
  output logic [CH_COUNT-1:0] serial_clock_out_o
);
  logic [PIN_COUNT-1:0] last_level = '0;
  logic [1:0] phase = '0;
  ////////////////////////////////////////////////////////////////////////////
  // Outside driver overpowers the port so a read can tell latch from pin;
  // a pin nobody drives shows the inverse of its last level, never a stale copy
  assign pin_level_o = (ext_drive_i & ext_level_i) | (~ext_drive_i & port_oe_i & port_out_i)
    | (~ext_drive_i & ~port_oe_i & ~last_level);
  // Channel stand-ins: data moves every cycle and clock every second cycle while the channel runs
  always @(posedge clk_i) begin
    last_level <= pin_level_o;
    phase <= serial_init_i ? 2'h0 : phase + 2'h1;
  end
  assign transmit_line_o = {~phase[0], phase[0]};
  assign serial_clock_out_o = {phase[1], phase[1]};
endmodule
`default_nettype wire

// >>> verification/tb_serial_shared_gpio_port.sv
`timescale 1ns/1ps
`default_nettype none
module tb_serial_shared_gpio_port;
  import gpio_port_pkg::*;
  logic clk_i = 1'h0;
  logic rst_i = 1'h1;
  logic hw_standby_i = 1'h0;
  logic sw_standby_i = 1'h0;
  logic [17:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [31:0] s_axi_wdata = '0;
  logic [3:0] s_axi_wstrb = '0;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  logic [PIN_COUNT-1:0] pin_i, pin_o, pin_oe_o;
  logic [PIN_COUNT-1:0] ext_drive = '0, ext_level = '0;
  logic [CH_COUNT-1:0] external_clock_in_enable_i = '0, internal_clock_out_enable_i = '0;
  logic [CH_COUNT-1:0] clocked_mode_i = '0, receiver_enable_i = '0, transmitter_enable_i = '0;
  logic [CH_COUNT-1:0] transmit_line_i, serial_clock_out_i, receive_line_o, serial_clock_in_o;
  logic serial_init_o;
  int miscompares = 0, samples_checked = 0;
  ////////////////////////////////////////////////////////////////////////////
  serial_shared_gpio_port DUT (
    .clk_i, .rst_i, .hw_standby_i, .sw_standby_i, .s_axi_awaddr, .s_axi_awprot(3'h0),
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arprot(3'h0), .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .pin_i, .pin_o, .pin_oe_o, .external_clock_in_enable_i,
    .internal_clock_out_enable_i, .clocked_mode_i, .receiver_enable_i,
    .transmitter_enable_i, .transmit_line_i, .serial_clock_out_i, .receive_line_o,
    .serial_clock_in_o, .serial_init_o
  );
  far_side_model far_side (
    .clk_i, .port_out_i(pin_o), .port_oe_i(pin_oe_o), .ext_drive_i(ext_drive),
    .ext_level_i(ext_level), .serial_init_i(serial_init_o), .pin_level_o(pin_i),
    .transmit_line_o(transmit_line_i), .serial_clock_out_o(serial_clock_out_i)
  );
  // Free-running system clock
  always #5 clk_i = ~clk_i;
  ////////////////////////////////////////////////////////////////////////////
  // Case equality so an unknown never passes
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] want);
    samples_checked++;
    if (seen !== want) begin
      miscompares++;
      $display("FAIL %s expected %h seen %h", what, want, seen);
    end
  endtask
  task automatic give_verdict;
    $display("Checks %0d, mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // Handshakes are judged between edges, where the slave's outputs are settled
  task automatic axi_write(input logic [17:0] addr, input logic [7:0] data,
                           input logic [3:0] strb, input logic [1:0] want);
    logic aw_hs, w_hs, b_hs;
    logic [1:0] resp;
    b_hs = 1'h0;
    @(posedge clk_i);
    s_axi_awaddr <= addr;
    s_axi_wdata <= {24'h0, data};
    s_axi_wstrb <= strb;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    while (!b_hs) begin
      @(negedge clk_i);
      aw_hs = s_axi_awvalid && s_axi_awready;
      w_hs = s_axi_wvalid && s_axi_wready;
      b_hs = s_axi_bvalid === 1'h1;
      resp = s_axi_bresp;
      @(posedge clk_i);
      if (aw_hs) s_axi_awvalid <= 1'h0;
      if (w_hs) s_axi_wvalid <= 1'h0;
    end
    s_axi_bready <= 1'h0;
    check("bresp", resp, want);
  endtask
  task automatic axi_read(input logic [17:0] addr, input logic [7:0] data,
                          input logic [1:0] want);
    logic ar_hs, r_hs;
    logic [31:0] seen;
    logic [1:0] resp;
    r_hs = 1'h0;
    @(posedge clk_i);
    s_axi_araddr <= addr;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    while (!r_hs) begin
      @(negedge clk_i);
      ar_hs = s_axi_arvalid && s_axi_arready;
      r_hs = s_axi_rvalid === 1'h1;
      seen = s_axi_rdata;
      resp = s_axi_rresp;
      @(posedge clk_i);
      if (ar_hs) s_axi_arvalid <= 1'h0;
    end
    s_axi_rready <= 1'h0;
    check("rdata", seen, {24'h0, data});
    check("rresp", resp, want);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // Main sequence; outside levels 2A overpower every pin throughout
  initial begin
    repeat (16) @(posedge clk_i);
    rst_i <= 1'h0;
    ext_drive <= 6'h3F;
    ext_level <= 6'h2A;
    repeat (4) @(posedge clk_i);
    check("pin_oe", pin_oe_o, 6'h00);
    axi_read(DIRECTION_ADDR, 8'hFF, RESP_OKAY);
    axi_read(DATA_ADDR, 8'hEA, RESP_OKAY);
    axi_write(DIRECTION_ADDR, 8'h36, 4'h1, RESP_OKAY);
    axi_write(DATA_ADDR, 8'h0F, 4'h1, RESP_OKAY);
    axi_write(DATA_ADDR, 8'h30, 4'h0, RESP_OKAY);
    @(negedge clk_i);
    check("pin_oe", pin_oe_o, 6'h36);
    check("pin_out", pin_o & 6'h36, 6'h06);
    axi_read(DIRECTION_ADDR, 8'hFF, RESP_OKAY);
    axi_read(DATA_ADDR, 8'hCE, RESP_OKAY);
    axi_write(18'h00100, 8'h3F, 4'h1, RESP_DECERR);
    axi_read(18'h00100, 8'h00, RESP_DECERR);
    // Transmit pins taken over by the channels, data moves on both levels
    @(posedge clk_i);
    transmitter_enable_i <= 2'h3;
    repeat (2) begin
      @(negedge clk_i);
      check("pin_oe", pin_oe_o, 6'h3F);
      check("tx_pins", {pin_o[3], pin_o[0]}, transmit_line_i);
    end
    // Latch written while the channel owns the pins shows once released
    axi_write(DIRECTION_ADDR, 8'h3F, 4'h1, RESP_OKAY);
    axi_write(DATA_ADDR, 8'h09, 4'h1, RESP_OKAY);
    transmitter_enable_i <= 2'h0;
    @(negedge clk_i);
    check("pin_out", pin_o, 6'h09);
    axi_read(DATA_ADDR, 8'hC9, RESP_OKAY);
    @(posedge clk_i);
    receiver_enable_i <= 2'h3;
    @(negedge clk_i);
    check("pin_oe", pin_oe_o, 6'h2D);
    axi_write(DIRECTION_ADDR, 8'h2D, 4'h1, RESP_OKAY);
    axi_read(DATA_ADDR, 8'hCB, RESP_OKAY);
    check("rx_lines", receive_line_o, 2'h1);
    check("clk_in_lines", serial_clock_in_o, 2'h2);
    // Every clock pin selection, both channels
    for (int c = 0; c < 2; c++) begin
      for (int k = 0; k < 4; k++) begin
        @(posedge clk_i);
        external_clock_in_enable_i[c] <= (k == 0);
        clocked_mode_i[c] <= (k == 0) || (k == 1);
        internal_clock_out_enable_i[c] <= (k == 0) || (k == 2);
        @(negedge clk_i);
        check("clk_pin_oe", pin_oe_o[3*c+2], k != 0);
        if (k != 0) begin
          check("clk_pin", pin_o[3*c+2], (k == 3) ? 1'h0 : serial_clock_out_i[c]);
        end
      end
    end
    // Software standby releases the pins but keeps both registers
    @(posedge clk_i);
    transmitter_enable_i <= 2'h3;
    sw_standby_i <= 1'h1;
    @(negedge clk_i);
    check("pin_oe", pin_oe_o, 6'h2D);
    check("pin_out", pin_o & 6'h2D, 6'h09);
    check("serial_init", serial_init_o, 1'h1);
    axi_read(DATA_ADDR, 8'hCB, RESP_OKAY);
    sw_standby_i <= 1'h0;
    transmitter_enable_i <= 2'h0;
    receiver_enable_i <= 2'h0;
    // Hardware standby reloads both registers
    @(posedge clk_i);
    hw_standby_i <= 1'h1;
    @(posedge clk_i);
    hw_standby_i <= 1'h0;
    @(negedge clk_i);
    check("pin_oe", pin_oe_o, 6'h00);
    axi_read(DATA_ADDR, 8'hEA, RESP_OKAY);
    axi_read(DIRECTION_ADDR, 8'hFF, RESP_OKAY);
    give_verdict();
  end
  // Watchdog: the sequence needs well under a thousand cycles
  initial begin
    #50000;
    miscompares++;
    give_verdict();
  end
endmodule
`default_nettype wire
